// [hw/eep_pkg.sv]
// =============================================================================
// Shared constants for the serial EEPROM protection and status block
package eep_pkg;

    // =========================================================================
    // Command opcodes, sent most significant bit first
    localparam logic [7:0] EEP_OP_WR_ENABLE  = 8'h06;
    localparam logic [7:0] EEP_OP_WR_DISABLE = 8'h04;
    localparam logic [7:0] EEP_OP_STAT_READ  = 8'h05;
    localparam logic [7:0] EEP_OP_STAT_WRITE = 8'h01;

    // =========================================================================
    // Status byte field positions
    localparam int unsigned EEP_SB_HW_PROT_EN = 7;
    localparam int unsigned EEP_SB_BLK_HI     = 3;
    localparam int unsigned EEP_SB_BLK_LO     = 2;
    localparam int unsigned EEP_SB_WEL        = 1;
    localparam int unsigned EEP_SB_WIP        = 0;

    // =========================================================================
    // Frame lengths in SCK rising edges
    localparam logic [4:0] EEP_CNT_OPCODE    = 5'h08;
    localparam logic [4:0] EEP_CNT_STAT_WR   = 5'h10;
    localparam logic [4:0] EEP_CNT_OP_LAST   = 5'h07;
    localparam logic [4:0] EEP_CNT_DATA_LAST = 5'h0f;
    localparam logic [4:0] EEP_CNT_TOP       = 5'h1f;
    localparam logic [4:0] EEP_CNT_WRAP      = 5'h18;

    // =========================================================================
    // Block protection boundaries (8192 byte array)
    localparam logic [12:0] EEP_ADDR_QUARTER = 13'h1800;
    localparam logic [12:0] EEP_ADDR_HALF    = 13'h1000;

    // =========================================================================
    // Values after power-up and default write cycle length
    localparam logic [2:0] EEP_NV_RESET    = 3'h0;
    localparam logic       EEP_WEL_RESET   = 1'b0;
    localparam int unsigned EEP_WR_CYC_DEF = 1000;

    typedef enum logic [1:0] {
        EEP_BLK_NONE,
        EEP_BLK_QUARTER,
        EEP_BLK_HALF,
        EEP_BLK_ALL
    } eep_blk_t;

endpackage

// [hw/eep_prot_status.sv]
`timescale 1ns/10ps
// Behaviour
// RL1: status write changes only nonvolatile bits
// RL2: block bits select protected address range
// RL3: hardware protect needs pin low, enable set
// RL4: hardware protect blocks only status writes
// RL5: status write cycle starts at chip-select rise
// RL6: enable bit 7, latch bit 1
// RL7: latch cleared at power-up
// RL8: host sets latch before any write
// RL9: latch cleared after every completed write
// RL10: write starts only on exact clock count
// RL11: array access ignored during write cycle
// RL12: standby at power-up, needs select fall
// RL13: latch, enable and pin combine for writes
// RL14: started write cycle completes despite deselect
// RL15: serial out released while deselected
// RL16: pin low during sequence blocks status write
// RL17: enable clear makes pin ignored
// RL18: sample on rising, shift on falling SCK
// RL19: decode four opcodes, MSB first
// RL20: write-in-progress bit reflects cycle
// RL21: block bits change only via status write
// RL22: host sends opcode plus one data byte
// RL23: host polls write-in-progress before next write
module eep_prot_status
    import eep_pkg::*;
#(
    parameter int unsigned P_WR_CYCLES = EEP_WR_CYC_DEF
) (
    // System clock and power-up reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_arst_n,
    // Serial link pins
    input  wire logic        i_spi_sck,
    input  wire logic        i_spi_cs_n,
    input  wire logic        i_spi_si,
    output logic             o_spi_so,
    output logic             o_spi_so_oe,
    input  wire logic        i_wp_n,
    // Array engine requests
    input  wire logic        i_arr_wr_req,
    input  wire logic [12:0] i_arr_wr_addr,
    input  wire logic        i_arr_rd_req,
    output logic             o_arr_wr_accept,
    output logic             o_arr_rd_grant,
    // Status view
    output logic [7:0]       o_status,
    output logic             o_hw_protect
);

    // =========================================================================
    // Block protection decode
    // The two block bits pick how much of the top of the array is locked.
    // Locked ranges always end at the last byte, so one lower bound is enough.
    // The decode is used by the array write gate only; status writes are
    // governed by the hardware protect logic further down.
    function automatic logic blk_protected(input logic [1:0] bp, input logic [12:0] addr);
        eep_blk_t lvl;
        lvl = eep_blk_t'(bp);
        // RL2: range decode
        unique case (lvl)
            EEP_BLK_NONE:    blk_protected = 1'b0;
            EEP_BLK_QUARTER: blk_protected = (addr >= EEP_ADDR_QUARTER);
            EEP_BLK_HALF:    blk_protected = (addr >= EEP_ADDR_HALF);
            EEP_BLK_ALL:     blk_protected = 1'b1;
        endcase
    endfunction

    // =========================================================================
    // Link domain state
    // Everything here runs on the serial clock, which only toggles inside a
    // frame. The frame part is cleared while chip select is high, so every
    // frame starts counting from zero. The kept part survives deselect and
    // carries the last opcode, data byte and bit count to the system side.
    // The system side reads the kept fields only after it has seen the
    // select rise through its synchroniser, by which time the serial clock
    // has stopped and the fields are quiet.
    // The frame toggle tells the system side that a fresh frame was clocked,
    // so an old frame is never executed twice on a later select rise.
    typedef struct packed {
        logic [4:0] cnt;
        logic [7:0] shift;
    } eep_frame_t;

    typedef struct packed {
        logic       tog;
        logic [4:0] cnt;
        logic [7:0] op;
        logic [7:0] data;
        logic [7:0] stat_s1;
        logic [7:0] stat_s2;
    } eep_keep_t;

    eep_frame_t frame_reg;
    eep_frame_t frame_next;
    eep_keep_t  keep_reg;
    eep_keep_t  keep_next;
    logic       so_reg;
    logic       so_next;
    logic       link_rst_n;
    logic [7:0] status_byte;

    // Frame logic restarts whenever chip select is high
    // A glitch on select simply restarts the frame, which the count check
    // then refuses, so no partial command can slip through.
    assign link_rst_n = i_arst_n & ~i_spi_cs_n;

    // Next link state on each rising SCK edge
    always_comb begin
        frame_next = frame_reg;
        keep_next  = keep_reg;
        // RL18: sample serial in
        frame_next.shift = {frame_reg.shift[6:0], i_spi_si};
        frame_next.cnt   = (frame_reg.cnt == EEP_CNT_TOP) ? EEP_CNT_WRAP
                         : frame_reg.cnt + 5'h01;
        keep_next.cnt    = frame_next.cnt;
        if (frame_reg.cnt == 5'h00) begin
            keep_next.tog = ~keep_reg.tog;   // Marks a new frame
        end
        // RL19: opcode capture
        if (frame_reg.cnt == EEP_CNT_OP_LAST) begin
            keep_next.op = frame_next.shift;
        end
        if (frame_reg.cnt == EEP_CNT_DATA_LAST) begin
            keep_next.data = frame_next.shift;
        end
        keep_next.stat_s1 = status_byte;
        keep_next.stat_s2 = keep_reg.stat_s1;
    end

    // Per-frame counters, cleared by deselect
    always_ff @(posedge i_spi_sck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            frame_reg <= '0;
        end else begin
            frame_reg <= frame_next;
        end
    end

    // Frame results kept across deselect
    always_ff @(posedge i_spi_sck or negedge i_arst_n) begin
        if (!i_arst_n) begin
            keep_reg <= '0;
        end else begin
            keep_reg <= keep_next;
        end
    end

    // Serial out driver
    // The status byte is brought into the serial clock domain through two
    // stages, so the first two edges of a frame still show an older status.
    // By the end of the opcode the copy is current, and the bit index wraps
    // every eight edges so the status can be read again and again.
    // RL18: status bit shifted out after falling edge
    always_comb begin
        so_next = keep_reg.stat_s2[3'h7 - frame_reg.cnt[2:0]];
    end

    always_ff @(negedge i_spi_sck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            so_reg <= 1'b0;
        end else begin
            so_reg <= so_next;
        end
    end

    assign o_spi_so = so_reg;
    // RL15: released while deselected
    assign o_spi_so_oe = ~i_spi_cs_n & (frame_reg.cnt >= EEP_CNT_OPCODE)
                       & (keep_reg.op == EEP_OP_STAT_READ);

    // =========================================================================
    // System domain state
    // Select, frame toggle and protect pin each pass two flip-flops before
    // any decision reads them. Commands act on the synchronised select rise.
    // The write timer only counts while a cycle runs and stops at its end.
    // Nonvolatile bits are held in flip-flops and reload from the pending
    // value when a status write cycle completes, not when it starts, so
    // the status read during the cycle still shows the old protection.
    typedef struct packed {
        logic        cs_s1;
        logic        cs_s2;
        logic        cs_prev;
        logic        tog_s1;
        logic        tog_s2;
        logic        tog_seen;
        logic        wp_s1;
        logic        wp_s2;
        logic        armed;
        logic        wp_low_seen;
        logic        write_enable_latch;
        logic        hw_protect_enable;
        logic [1:0]  bp;
        logic        write_in_progress;
        logic        nv_pend;
        logic [2:0]  nv_new;
        logic [19:0] timer;
        logic        wr_acc;
    } eep_sys_t;

    eep_sys_t sys_reg;
    eep_sys_t sys_next;
    logic     hw_prot;
    logic     cs_rise;
    logic     cs_fall;
    logic     frame_seen;

    // RL3: hardware protect from synchronised pin and enable bit
    // RL17: pin ignored while enable is clear
    assign hw_prot = sys_reg.hw_protect_enable & ~sys_reg.wp_s2;
    assign cs_rise = sys_reg.cs_s2 & ~sys_reg.cs_prev;
    assign cs_fall = ~sys_reg.cs_s2 & sys_reg.cs_prev;
    assign frame_seen = sys_reg.tog_s2 ^ sys_reg.tog_seen;

    // RL6: status byte layout
    always_comb begin
        status_byte = 8'h00;
        status_byte[EEP_SB_HW_PROT_EN] = sys_reg.hw_protect_enable;
        status_byte[EEP_SB_BLK_HI]     = sys_reg.bp[1];
        status_byte[EEP_SB_BLK_LO]     = sys_reg.bp[0];
        status_byte[EEP_SB_WEL]        = sys_reg.write_enable_latch;
        // RL20: busy flag
        status_byte[EEP_SB_WIP]        = sys_reg.write_in_progress;
    end

    // Command completion, write cycle timing and array gating
    // Priority: a running cycle first, then a finished frame, then the
    // array request. While busy every frame except a status read is lost,
    // which matches the rule that access during a cycle is ignored.
    // A frame that ends during a cycle is marked seen so that it does not
    // fire later, once the cycle is over.
    // The pin-low memory covers a pin that pulses low mid-frame and is high
    // again by the time select rises.
    always_comb begin
        sys_next         = sys_reg;
        sys_next.cs_s1   = i_spi_cs_n;
        sys_next.cs_s2   = sys_reg.cs_s1;
        sys_next.cs_prev = sys_reg.cs_s2;
        sys_next.tog_s1  = keep_reg.tog;
        sys_next.tog_s2  = sys_reg.tog_s1;
        sys_next.wp_s1   = i_wp_n;
        sys_next.wp_s2   = sys_reg.wp_s1;
        sys_next.wr_acc  = 1'b0;
        // RL12: a select fall arms the command decoder
        if (cs_fall) begin
            sys_next.armed       = 1'b1;
            sys_next.wp_low_seen = 1'b0;
        end
        // RL16: pin low anywhere in the sequence counts
        if (!sys_reg.cs_s2 && !sys_reg.wp_s2) begin
            sys_next.wp_low_seen = 1'b1;
        end
        // RL14: cycle runs to its end regardless of select
        if (sys_reg.write_in_progress) begin
            if (sys_reg.timer == 20'(P_WR_CYCLES - 1)) begin
                sys_next.write_in_progress   = 1'b0;
                sys_next.timer = '0;
                // RL9: latch cleared on completion
                sys_next.write_enable_latch   = 1'b0;
                // RL1: only nonvolatile bits updated
                // RL21: block bits written only here
                if (sys_reg.nv_pend) begin
                    {sys_next.hw_protect_enable, sys_next.bp} = sys_reg.nv_new;
                    sys_next.nv_pend = 1'b0;
                end
            end else begin
                sys_next.timer = sys_reg.timer + 20'h00001;
            end
        end else if (cs_rise && frame_seen && sys_reg.armed) begin
            sys_next.tog_seen = sys_reg.tog_s2;
            // RL10: exact bit count required
            if (keep_reg.cnt == EEP_CNT_OPCODE
                    && keep_reg.op == EEP_OP_WR_ENABLE) begin
                sys_next.write_enable_latch = 1'b1;
            end else if (keep_reg.cnt == EEP_CNT_OPCODE
                    && keep_reg.op == EEP_OP_WR_DISABLE) begin
                sys_next.write_enable_latch = 1'b0;
            // RL13: latch set and status not hardware protected
            // RL4: status write refused under hardware protect
            // RL16: enable and pin low during sequence block it
            end else if (keep_reg.cnt == EEP_CNT_STAT_WR
                    && keep_reg.op == EEP_OP_STAT_WRITE && sys_reg.write_enable_latch
                    && !(sys_reg.hw_protect_enable && (sys_reg.wp_low_seen || !sys_reg.wp_s2))) begin
                // RL5: cycle begins on select rise
                sys_next.write_in_progress     = 1'b1;
                sys_next.nv_pend = 1'b1;
                sys_next.nv_new  = {keep_reg.data[EEP_SB_HW_PROT_EN],
                                    keep_reg.data[EEP_SB_BLK_HI],
                                    keep_reg.data[EEP_SB_BLK_LO]};
            end
        end else if (i_arr_wr_req && sys_reg.write_enable_latch
                     && !blk_protected(sys_reg.bp, i_arr_wr_addr)) begin
            // RL13: unprotected blocks writable with latch set
            sys_next.write_in_progress    = 1'b1;
            sys_next.wr_acc = 1'b1;
        end
        // Frames that end during a cycle are dropped
        if (cs_rise) begin
            sys_next.tog_seen = sys_reg.tog_s2;
        end
    end

    // Power-up reset
    // Select and pin copies reset to their idle high level, so the first
    // edges after reset show no false select edge and no false pin low.
    // RL7: latch and cycle state cleared at power-up
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sys_reg       <= '0;
            sys_reg.cs_s1 <= 1'b1;
            sys_reg.cs_s2 <= 1'b1;
            sys_reg.cs_prev <= 1'b1;
            sys_reg.wp_s1 <= 1'b1;
            sys_reg.wp_s2 <= 1'b1;
            sys_reg.write_enable_latch   <= EEP_WEL_RESET;
            {sys_reg.hw_protect_enable, sys_reg.bp} <= EEP_NV_RESET;
        end else begin
            sys_reg <= sys_next;
        end
    end

    // =========================================================================
    // Outputs
    // Accept is a registered one-cycle pulse; read grant is a plain gate so
    // the requester sees the refusal in the same cycle it asks.
    assign o_arr_wr_accept = sys_reg.wr_acc;
    // RL11: array access ignored while busy
    assign o_arr_rd_grant  = i_arr_rd_req & ~sys_reg.write_in_progress;
    assign o_status        = status_byte;
    assign o_hw_protect    = hw_prot;

endmodule // eep_prot_status

// [sim/eep_prot_assertions.sv]
`timescale 1ns/10ps
// ==========================================
// Port checker
module eep_prot_chk (
    // Clock and reset
    input wire logic       i_clk_sys,
    input wire logic       i_arst_n,
    // Watched ports
    input wire logic       i_spi_cs_n,
    input wire logic       o_spi_so_oe,
    input wire logic       o_arr_wr_accept,
    input wire logic       o_arr_rd_grant,
    input wire logic [7:0] o_status,
    input wire logic       o_hw_protect
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    // Status and handshake relations
    so_release_a: assert property (i_spi_cs_n |-> !o_spi_so_oe)
        else $error("serial out driven while deselected");
    hw_needs_en_a: assert property (o_hw_protect |-> o_status[7])
        else $error("protect without enable bit");
    pin_ignored_a: assert property (!o_status[7] |-> !o_hw_protect)
        else $error("pin acts with enable clear");
    acc_sets_wip_a: assert property (o_arr_wr_accept |-> ##[0:1] o_status[0])
        else $error("accepted write without busy bit");
    acc_needs_wel_a: assert property (o_arr_wr_accept |-> $past(o_status[1]))
        else $error("write accepted with latch clear");
    busy_no_read_a: assert property (o_status[0] |-> !o_arr_rd_grant)
        else $error("read granted during write cycle");
    wip_holds_a: assert property ($rose(o_status[0]) |-> o_status[0] [*8])
        else $error("write cycle cut short");
    wel_clears_a: assert property ($fell(o_status[0]) |-> !o_status[1])
        else $error("latch still set after write");
    all_locked_a: assert property
        ((&o_status[3:2]) && $past(&o_status[3:2]) |-> !o_arr_wr_accept)
        else $error("write accepted in locked array");
    resv_zero_a: assert property (o_status[6:4] == 3'h0)
        else $error("reserved status bits set");
    // Main scenarios reached
    cover property (o_arr_wr_accept);
    cover property (o_hw_protect);
    cover property (o_spi_so_oe);
endmodule // eep_prot_chk

bind eep_prot_status eep_prot_chk u_chk (
    .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_spi_cs_n(i_spi_cs_n),
    .o_spi_so_oe(o_spi_so_oe), .o_arr_wr_accept(o_arr_wr_accept),
    .o_arr_rd_grant(o_arr_rd_grant), .o_status(o_status), .o_hw_protect(o_hw_protect)
);

// [sim/eep_host_model.sv]
`timescale 1ns/10ps
// ==========================================
// Host master on the serial link
module eep_host_model (
    // Link pins
    output logic      o_sck  = 1'b0,
    output logic      o_cs_n = 1'b1,
    output logic      o_si   = 1'b0,
    input  wire logic i_so,
    input  wire logic i_so_oe
);
    // Released line reads as pulled up
    wire so_line = i_so_oe ? i_so : 1'b1;

    task automatic frame(input logic [15:0] bits, input int n, output logic [7:0] rd);
        rd = 8'h00;
        #1.3 o_cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            o_si = bits[15-i];
            #3 o_sck = 1'b1;
            rd = {rd[6:0], so_line};
            #3 o_sck = 1'b0;
        end
        #3 o_cs_n = 1'b1;
        o_si = ~o_si;
    endtask
endmodule // eep_host_model

// [sim/tb_top.sv]
`timescale 1ns/10ps
// ==========================================
// Bench for the protection block
module tb_top;
    import eep_pkg::*;
    localparam int unsigned P_WR = 20;
    // Bench signals
    logic        i_clk_sys = 1'b0;
    logic        i_arst_n  = 1'b0;
    logic        i_wp_n    = 1'b1;
    logic        wr_req    = 1'b0;
    logic [12:0] wr_addr   = 13'h0000;
    logic        rd_req    = 1'b0;
    logic        sck, cs_n, si, so, so_oe, accept, grant, hwp;
    logic [7:0]  status, rd;
    int          errors    = 0;
    int          checked   = 0;

    eep_prot_status #(.P_WR_CYCLES(P_WR)) dut (
        .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_spi_sck(sck), .i_spi_cs_n(cs_n),
        .i_spi_si(si), .o_spi_so(so), .o_spi_so_oe(so_oe), .i_wp_n(i_wp_n),
        .i_arr_wr_req(wr_req), .i_arr_wr_addr(wr_addr), .i_arr_rd_req(rd_req),
        .o_arr_wr_accept(accept), .o_arr_rd_grant(grant), .o_status(status),
        .o_hw_protect(hwp));
    eep_host_model host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so), .i_so_oe(so_oe));

    // System clock
    initial begin
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask
    // Compare off the edge
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        #1;
        checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] op, input logic [7:0] d, input int n);
        host.frame({op, d}, n, rd);
        cyc(8);
    endtask
    task automatic poll();
        int k;
        k = 0;
        #1;
        while (k < 100 && status[0] !== 1'b0) begin
            cyc(1);
            #1 k++;
        end
        if (k >= 100) begin
            errors++;                           // Busy bit never cleared
        end
        cyc(1);
    endtask
    task automatic wr_status(input logic [7:0] d);
        cmd(EEP_OP_WR_ENABLE, 8'h00, 8);
        cmd(EEP_OP_STAT_WRITE, d, 16);
        poll();
    endtask
    task automatic arr(input logic [12:0] a, input logic e);
        logic acc;
        acc = 1'b0;
        @(posedge i_clk_sys);
        wr_req  <= 1'b1;
        wr_addr <= a;
        @(posedge i_clk_sys);
        wr_req <= 1'b0;
        repeat (3) begin
            #1 acc |= accept;
            cyc(1);
        end
        chk({7'h00, acc}, {7'h00, e});
    endtask
    // Scenarios
    task automatic t_latch();
        cmd(EEP_OP_WR_ENABLE, 8'h00, 8);
        chk(status, 8'h02);                     // latch set
        cmd(EEP_OP_WR_DISABLE, 8'h00, 8);
        chk(status, 8'h00);                     // latch clear
        cmd(EEP_OP_WR_ENABLE, 8'h00, 7);
        chk(status, 8'h00);                     // short frame
        cmd(EEP_OP_WR_ENABLE, 8'h00, 9);
        chk(status, 8'h00);                     // long frame
    endtask
    task automatic t_stat();
        cmd(EEP_OP_WR_ENABLE, 8'h00, 8);        // latch first
        cmd(EEP_OP_STAT_WRITE, 8'hff, 16);
        chk(status, 8'h03);                     // cycle running
        poll();
        chk(status, 8'h8c);                     // bits only
        host.frame({EEP_OP_STAT_READ, 8'h00}, 16, rd);
        chk(rd, 8'h8c);                         // read back
        chk({7'h00, so_oe}, 8'h00);             // released
    endtask
    task automatic t_hw();
        cyc(1);
        i_wp_n <= 1'b0;
        cyc(4);
        chk({7'h00, hwp}, 8'h01);               // pin and enable
        wr_status(8'h00);
        cyc(P_WR + 5);
        chk(status, 8'h8e);                     // status refused
        cyc(1);
        rd_req <= 1'b1;
        #1;
        chk({7'h00, grant}, 8'h01);             // read still served
        cyc(1);
        rd_req <= 1'b0;
        arr(13'h0000, 1'b0);                    // all locked
        i_wp_n <= 1'b1;
        cyc(4);
        cmd(EEP_OP_WR_ENABLE, 8'h00, 8);
        cmd(EEP_OP_STAT_WRITE, 8'h84, 16);
        i_wp_n <= 1'b0;
        poll();
        chk(status, 8'h84);                     // late pin fall
        i_wp_n <= 1'b1;
        cyc(4);
        wr_status(8'h08);
        i_wp_n <= 1'b0;
        cyc(4);
        chk({7'h00, hwp}, 8'h00);               // pin ignored
        wr_status(8'h04);
        chk(status, 8'h04);                     // still writable
    endtask
    task automatic arr_case(input logic [1:0] bp, input logic [12:0] a, input logic e);
        wr_status({4'h0, bp, 2'b00});
        cmd(EEP_OP_WR_ENABLE, 8'h00, 8);        // latch first
        arr(a, e);                              // block range
        if (e) begin
            rd_req <= 1'b1;
            #1;
            chk({7'h00, grant}, 8'h00);         // busy read
            arr(13'h0000, 1'b0);                // busy write
            rd_req <= 1'b0;
        end
        poll();
        chk(status, {4'h0, bp, ~e, 1'b0});      // latch cleared only after an accepted write
    endtask

    task automatic print_verdict();
        if (errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #100000;
        errors++;
        print_verdict();
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        cyc(5);
        chk(status, 8'h00);                     // standby
        chk({6'h00, so_oe, hwp}, 8'h00);        // released
        t_latch();
        t_stat();
        t_hw();
        arr_case(2'b01, 13'h17ff, 1'b1);
        arr_case(2'b01, 13'h1800, 1'b0);
        arr_case(2'b10, 13'h0fff, 1'b1);
        arr_case(2'b10, 13'h1000, 1'b0);
        arr_case(2'b00, 13'h1fff, 1'b1);
        print_verdict();
    end
endmodule // tb_top
